/* bench/qco_assertions.sv */
/*
 * Port checker for the quad change-over controller.
 * Assumes a bind from the bench top and a short millisecond divider.
 */
`timescale 1ns/1ps
module qco_assertions
#(
    parameter int MS_DIV = 20
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] local_override_switch,
    input wire qco_pkg::qco_health_t health,
    input wire qco_pkg::qco_fmt_t fmt,
    input wire logic [7:0] rck_enable_cfg,
    input wire logic [7:0] autobypass_cfg,
    input wire logic [3:0] output_port_sel_b,
    input wire logic [3:0] output_port_mute,
    input wire logic [7:0] rck_pass_thru,
    input wire logic [3:0] slew_sd
);
    import qco_pkg::*;
    // ==========================================================
    // Settle counters; hold and lock are zero under the switches
    localparam int LIM = 2 * MS_DIV + 40;
    logic [31:0] ok_cnt_r;
    logic [31:0] bad_cnt_r;
    logic [31:0] quad_cnt_r;
    logic dip_ind;
    logic [7:0] sw;
    assign sw = local_override_switch;
    assign dip_ind = sw[7] && !sw[6] && (sw[3:1] == 3'h0);
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst || !(dip_ind && health.sig_a[0] && !output_port_mute[0]))
            ok_cnt_r <= 32'h0;
        else if (ok_cnt_r <= LIM)
            ok_cnt_r <= ok_cnt_r + 32'h1;
    end
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst || !(dip_ind && !health.sig_a[0] && health.sig_b[0] && !output_port_mute[0]))
            bad_cnt_r <= 32'h0;
        else if (bad_cnt_r <= LIM)
            bad_cnt_r <= bad_cnt_r + 32'h1;
    end
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst || !(sw[7] && sw[6] && output_port_mute == 4'h0))
            quad_cnt_r <= 32'h0;
        else if (quad_cnt_r <= LIM)
            quad_cnt_r <= quad_cnt_r + 32'h1;
    end
    // ==========================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_ready_access: assert property (s_setup ##1 s_access |-> pready)
        else $error("pready missing in access phase");
    a_ready_qualified: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held two cycles");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_dip_main_kept: assert property (ok_cnt_r == LIM |-> !output_port_sel_b[0])
        else $error("healthy main not selected");
    a_dip_to_backup: assert property (bad_cnt_r == LIM |-> output_port_sel_b[0])
        else $error("failed main kept");
    a_quad_together: assert property (quad_cnt_r == LIM |-> output_port_sel_b inside {4'h0, 4'hF})
        else $error("quad streams split");
    a_mute_sel_frozen: assert property ((output_port_mute & $past(output_port_mute)
        & (output_port_sel_b ^ $past(output_port_sel_b))) == 4'h0)
        else $error("select moved inside break");
    a_slew_forced: assert property ($stable(fmt.below_sd) [*4] |-> (slew_sd & fmt.below_sd) == fmt.below_sd)
        else $error("low rate stream not on SD slew");
    a_pass_needs_rck: assert property ((!sw[7] && $stable({rck_enable_cfg, autobypass_cfg, fmt})) [*4] |->
        rck_pass_thru == (~rck_enable_cfg | (autobypass_cfg & ~{2{fmt.fmt_ok}})))
        else $error("pass through not as configured");
endmodule // qco_assertions

/* bench/qco_src.sv */
/*
 * Upstream source model: drives stream health and format flags.
 * Assumes the bench sets the wanted values; slow mode lands them every 8th cycle.
 */
`timescale 1ns/1ps
module qco_src
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic slow,
    input wire qco_pkg::qco_health_t want_health,
    input wire qco_pkg::qco_fmt_t want_fmt,
    output qco_pkg::qco_health_t health,
    output qco_pkg::qco_fmt_t fmt
);
    import qco_pkg::*;
    logic [2:0] wait_r;
    // Cable replug latency, so edges never line up with bench steps
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wait_r <= 3'h0;
            health <= 16'hFFFF;
            fmt <= 8'h00;
        end
        else if (slow && wait_r != 3'h7)
            wait_r <= wait_r + 3'h1;
        else
        begin
            wait_r <= 3'h0;
            health <= want_health;
            fmt <= want_fmt;
        end
    end
endmodule // qco_src

/* bench/qco_tb_top.sv */
/*
 * Self-checking bench for the quad change-over controller.
 * Assumes zero-wait APB answers and a 20-cycle millisecond.
 */
`timescale 1ns/1ps
module qco_tb_top;
    import qco_pkg::*;
    localparam int MS = 20;
    localparam int BRK = 3;
    typedef struct packed { logic err; logic [31:0] mask; logic [31:0] data; } qco_exp_t;
    logic ref_clk = 1'b0;
    logic rst, psel, penable, pwrite, pready, pslverr, slow, led_flash;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] dip, eq_cfg, rck_cfg, ab_cfg, rck_pass, eq_byp;
    logic [3:0] sel_b, mute, slew;
    qco_health_t want_h, health;
    qco_fmt_t want_f, fmt;
    qco_exp_t exp_q[$];
    qco_exp_t cur;
    int bad_count, check_count, seed, n, k;
    always #2.5 ref_clk = ~ref_clk;
    qco_top #(.MS_DIV(MS), .BREAK_TICKS(BRK)) i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .local_override_switch(dip), .health(health), .fmt(fmt),
        .eq_bypass_cfg(eq_cfg), .rck_enable_cfg(rck_cfg), .autobypass_cfg(ab_cfg),
        .output_port_sel_b(sel_b), .output_port_mute(mute), .rck_pass_thru(rck_pass),
        .eq_bypass(eq_byp), .slew_sd(slew), .led_flash(led_flash));
    qco_src i_src (.ref_clk(ref_clk), .rst(rst), .slow(slow), .want_health(want_h), .want_fmt(want_f),
        .health(health), .fmt(fmt));
    // ==========================================================
    // Reporting
    task stop_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task cmp32(input logic [31:0] got, input logic [31:0] want);
        check_count++;
        if (got !== want)
        begin
            bad_count++;
            $display("BAD t=%0t got=%h want=%h", $time, got, want);
        end
    endtask
    task cmp1(input logic got, input logic want);
        cmp32({31'h0, got}, {31'h0, want});
    endtask
    // ==========================================================
    // Bus and stimulus helpers; reads expect data & mask, writes mask 0
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m, input logic e);
        int i;
        exp_q.push_back({e, m, d & m});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 16 && pready !== 1'b1; i++)
            @(posedge ref_clk);
        if (i == 16)
        begin
            bad_count++;
            stop_test;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask
    task st(input logic [3:0] s);
        apb(1'b0, OFS_STATUS, {24'h0, s, 4'h0}, 32'hF0, 1'b0);
    endtask
    task sh(input logic [15:0] h, input int t);
        want_h <= h;
        repeat (t) @(posedge ref_clk);
    endtask
    function automatic logic [31:0] cho(input logic [1:0] md, input logic mb, input logic lol, input logic lt,
        input logic [12:0] hold, input logic [12:0] lock);
        return {1'b0, lock, hold, lt, lol, mb, md};
    endfunction
    // ==========================================================
    // Result watcher
    always @(posedge ref_clk)
        if (psel && penable && pready === 1'b1)
        begin
            if (exp_q.size() == 0)
                cmp1(1'b1, 1'b0);
            else
            begin
                cur = exp_q.pop_front();
                cmp32(prdata & cur.mask, cur.data);
                cmp1(pslverr, cur.err);
            end
        end
    // ==========================================================
    // Main sequence
    initial
    begin
        seed = 75190;
        rst = 1'b1;
        {psel, penable, pwrite, slow} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        {dip, eq_cfg, rck_cfg, ab_cfg} = 32'h0000FF00;
        want_h = 16'hFFFF;
        want_f = 8'($random(seed));
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (n = 0; n < 4; n++)
            apb(1'b0, OFS_CHO0 + 12'(4 * n), CHO_RST, 32'hFFFF_FFFF, 1'b0);
        apb(1'b0, OFS_GLOBAL, GLOBAL_RST, 32'hFFFF_FFFF, 1'b0);
        apb(1'b1, 12'h030, 32'h5, 32'h0, 1'b1);
        apb(1'b0, 12'h030, 32'h0, 32'hFFFF_FFFF, 1'b1);
        wr(OFS_CHO0 + 12'h4, cho(2'h0, 1'b0, 1'b0, 1'b0, 13'h1FFF, 13'h1FFF));
        apb(1'b0, OFS_CHO0 + 12'h4, cho(2'h0, 1'b0, 1'b0, 1'b0, 13'h1FFF, 13'h1FFF), 32'hFFFF_FFFF, 1'b0);
        wr(OFS_CHO0 + 12'h4, 32'h0);
        wr(OFS_CHO0, cho(2'h0, 1'b0, 1'b0, 1'b0, 13'h5, 13'h3));
        sh(16'hEFFF, 60);
        st(4'h0);
        sh(16'hEFFF, 200);
        st(4'h1);
        sh(16'hFFFF, 40);
        st(4'h1);
        sh(16'hFFFF, 200);
        st(4'h0);
        wr(OFS_CHO0, cho(2'h0, 1'b0, 1'b0, 1'b1, 13'h0, 13'h0));
        sh(16'hEFFF, 100);
        sh(16'hFFFF, 200);
        st(4'h1);
        wr(OFS_GLOBAL, 32'h4);
        sh(16'hFFFF, 100);
        st(4'h0);
        wr(OFS_CHO0, cho(QCO_MODE_FIX_A, 1'b0, 1'b0, 1'b0, 13'h0, 13'h0));
        sh(16'hEFFF, 100);
        st(4'h0);
        wr(OFS_CHO0, cho(QCO_MODE_FIX_B, 1'b0, 1'b0, 1'b0, 13'h0, 13'h0));
        sh(16'hFFFF, 100);
        st(4'h1);
        wr(OFS_CHO0, cho(QCO_MODE_AUTO, 1'b1, 1'b1, 1'b0, 13'h0, 13'h0));
        sh(16'hFFFF, 100);
        st(4'h1);
        sh(16'hFFFE, 100);
        st(4'h0);
        wr(OFS_CHO0, cho(QCO_MODE_AUTO, 1'b0, 1'b0, 1'b0, 13'h0, 13'h0));
        wr(OFS_CHO0 + 12'h4, cho(QCO_MODE_FIX_A, 1'b0, 1'b0, 1'b0, 13'h0, 13'h0));
        wr(OFS_GLOBAL, 32'h1);
        sh(16'hFFFF, 100);
        st(4'h0);
        sh(16'hBFFF, 100);
        st(4'hF);
        sh(16'hBCFF, 100);
        st(4'h0);
        wr(OFS_CHO0, cho(QCO_MODE_AUTO, 1'b1, 1'b0, 1'b0, 13'h0, 13'h0));
        sh(16'hC3FF, 100);
        st(4'hF);
        wr(OFS_GLOBAL, 32'h2);
        apb(1'b0, OFS_CHO0, cho(2'h0, 1'b1, 1'b0, 1'b0, 13'h0, 13'h0), 32'hFFFF_FFFF, 1'b0);
        wr(OFS_CHO0, 32'h0);
        sh(16'hFFFF, 300);
        sh(16'hEFFF, 0);
        for (n = 0; n < 200 && mute[0] !== 1'b1; n++)
            @(posedge ref_clk);
        for (k = 0; k < 200 && mute[0] === 1'b1; k++)
            @(posedge ref_clk);
        cmp1(k >= (BRK - 1) * MS && k <= (BRK + 1) * MS + 2, 1'b1);
        wr(OFS_GLOBAL, 32'h0);
        wr(OFS_CHO0, cho(QCO_MODE_FIX_B, 1'b0, 1'b0, 1'b0, 13'h0, 13'h0));
        dip <= 8'h80;
        sh(16'hFFFF, 200);
        st(4'h0);
        cmp32({24'h000000, eq_byp}, 32'h0000_00FF);
        sh(16'hEFFF, 200);
        st(4'h1);
        dip <= 8'h82;
        sh(16'hFFFF, 200);
        st(4'hF);
        dip <= 8'hC0;
        sh(16'hBFFF, 200);
        st(4'hF);
        dip <= 8'h00;
        wr(OFS_LOCATE, 32'h1);
        for (n = 0; n < 21000 && led_flash !== 1'b1; n++)
            @(posedge ref_clk);
        cmp1(n < 21000, 1'b1);
        repeat (21000) @(posedge ref_clk);
        for (n = 0, k = 0; n < 2000; n++)
            @(posedge ref_clk) k += int'(led_flash === 1'b1);
        cmp32(32'(k), 32'h0);
        // Random settings and formats; checker watches slew and pass through
        for (n = 0; n < 20; n++)
        begin
            {eq_cfg, rck_cfg, ab_cfg, want_f} <= $random(seed);
            slow <= n[0];
            repeat (30) @(posedge ref_clk);
        end
        stop_test;
    end
endmodule // qco_tb_top
bind qco_top qco_assertions #(.MS_DIV(MS_DIV)) i_chk (.ref_clk, .rst, .psel, .penable, .pready, .pslverr,
    .local_override_switch, .health, .fmt, .rck_enable_cfg, .autobypass_cfg, .output_port_sel_b,
    .output_port_mute, .rck_pass_thru, .slew_sd);

/* hdl/qco_pkg.sv */
/*
 * Shared constants, types and register map of the quad change-over controller.
 * Assumes a 200 MHz system clock and an APB master with 32-bit data.
 */
package qco_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_MHZ = 200;
    localparam int MS_CYCLES = CLK_MHZ * 1000;
    localparam int BREAK_MS = 1000;
    localparam int LOCATE_DEF_S = 120;
    localparam logic [12:0] TIME_MAX_MS_W = 13'h1387;
    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] OFS_GLOBAL = 12'h000;
    localparam logic [11:0] OFS_CHO0 = 12'h010;
    localparam logic [11:0] OFS_STATUS = 12'h020;
    localparam logic [11:0] OFS_LOCATE = 12'h024;
    localparam logic [11:0] OFS_FMT = 12'h028;
    // ==========================================================
    // Field positions
    localparam int GB_QUAD = 0;
    localparam int GB_BREAK = 1;
    localparam int GB_RESET = 2;
    localparam int CB_MODE = 0;
    localparam int CB_MAINB = 2;
    localparam int CB_LOL = 3;
    localparam int CB_LATCH = 4;
    localparam int CB_HOLD = 5;
    localparam int CB_LOCK = 18;
    localparam int DIP_MAINB = 1;
    localparam int DIP_LOL = 2;
    localparam int DIP_LATCH = 3;
    localparam int DIP_RCK = 4;
    localparam int DIP_EQ = 5;
    localparam int DIP_QUAD = 6;
    localparam int DIP_OVR = 7;
    // ==========================================================
    // Reset values
    localparam logic [31:0] CHO_RST = 32'h0000_0000;
    localparam logic [31:0] GLOBAL_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        QCO_MODE_AUTO = 2'h0,
        QCO_MODE_FIX_A = 2'h1,
        QCO_MODE_FIX_B = 2'h2
    } qco_mode_t;

    typedef enum logic [1:0] {
        QCO_SLEW_AUTO = 2'h0,
        QCO_SLEW_SD = 2'h1,
        QCO_SLEW_HD = 2'h2
    } qco_slew_t;

    typedef struct packed {
        qco_mode_t mode;
        logic main_b;
        logic rule_lol;
        logic latch;
        logic [12:0] hold_ms;
        logic [12:0] lock_ms;
    } qco_cfg_t;

    typedef struct packed {
        logic [3:0] sig_a;
        logic [3:0] sig_b;
        logic [3:0] lock_a;
        logic [3:0] lock_b;
    } qco_health_t;

    typedef struct packed {
        logic [3:0] fmt_ok;
        logic [3:0] below_sd;
    } qco_fmt_t;

    function automatic logic [31:0] qco_div_up(input logic [31:0] n, input logic [31:0] d);
        return (n + d - 32'h1) / d;
    endfunction
endpackage

/* hdl/qco_top.sv */
/*
 * Quad 2x1 change-over controller: per-block selection state, timers, latch,
 * quad grouping, defined break, reclocker bypass, slew choice and locate flash.
 * Assumes synchronous health and DIP inputs, an APB master on the register port.
 */
// Decided for this implementation: the register addresses and the APB register port.
// Operation
// - Independent mode: four separate change-over blocks; a defined break mutes all four outputs
// - Quad mode: all switch together on trigger
// - Quad mode uses block one settings
// - Both groups faulty: pick more healthy group
// - Equal health: pick configured main group
// - Defined break about one second, else immediate
// - Auto mode plus fixed A, fixed B
// - Configured main preferred, other is backup
// - Latch holds backup until reset command
// - Main to backup after fault exceeds hold
// - Backup to main after clean exceeds lock
// - Fault is signal loss or lock loss
// - Autobypass only while reclocker enabled
// - Auto slew; SD below 270 Mb/s
// - Locate flashes indicators, 120 s default
// - Mode change needs no reboot
// - Override switch selects local switches
// - Local switch bit encoding
`timescale 1ns/1ps
module qco_top
    import qco_pkg::*;
#(
    parameter int MS_DIV = qco_pkg::MS_CYCLES,
    parameter int BREAK_TICKS = qco_pkg::BREAK_MS
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] local_override_switch,
    input wire qco_pkg::qco_health_t health,
    input wire qco_pkg::qco_fmt_t fmt,
    input wire logic [7:0] eq_bypass_cfg,
    input wire logic [7:0] rck_enable_cfg,
    input wire logic [7:0] autobypass_cfg,
    output logic [3:0] output_port_sel_b,
    output logic [3:0] output_port_mute,
    output logic [7:0] rck_pass_thru,
    output logic [7:0] eq_bypass,
    output logic [3:0] slew_sd,
    output logic led_flash
);
    import qco_pkg::*;

    initial
    begin
        if (MS_DIV < 2 || BREAK_TICKS < 1)
        begin
            $error("qco_top: bad timing parameters");
        end
    end

    // ==========================================================
    // Registers
    logic [31:0] global_r;
    logic [31:0] cho_r [4];
    logic [15:0] locate_s_r;
    logic locate_go_r;
    logic wr_en;

    assign wr_en = psel && penable && pwrite;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            global_r <= GLOBAL_RST;
            locate_s_r <= 16'h0000;
            locate_go_r <= 1'b0;
            for (int i = 0; i < 4; i++)
            begin
                cho_r[i] <= CHO_RST;
            end
        end
        else
        begin
            global_r[GB_RESET] <= 1'b0;
            locate_go_r <= 1'b0;
            if (wr_en)
            begin
                if (paddr == OFS_GLOBAL)
                begin
                    global_r <= pwdata;
                end
                if (paddr == OFS_LOCATE)
                begin
                    locate_s_r <= pwdata[15:0];
                    locate_go_r <= 1'b1;
                end
                for (int i = 0; i < 4; i++)
                begin
                    if (paddr == OFS_CHO0 + 12'(4 * i))
                    begin
                        cho_r[i] <= pwdata;
                    end
                end
            end
        end
    end

    // ==========================================================
    // APB answer, zero wait states
    logic [3:0] sel_b_r;
    logic [3:0] mute_r;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable)
            begin
                prdata <= 32'h0000_0000;
                pslverr <= !(paddr == OFS_GLOBAL || paddr == OFS_STATUS || paddr == OFS_LOCATE ||
                    paddr == OFS_FMT || (paddr >= OFS_CHO0 && paddr <= OFS_CHO0 + 12'hC && paddr[1:0] == 2'h0));
                if (paddr == OFS_GLOBAL)
                begin
                    prdata <= global_r;
                end
                if (paddr == OFS_STATUS)
                begin
                    prdata <= {16'h0000, health.sig_a & ~health.lock_a, mute_r, sel_b_r, 4'h0};
                end
                if (paddr == OFS_LOCATE)
                begin
                    prdata <= {16'h0000, locate_s_r};
                end
                if (paddr == OFS_FMT)
                begin
                    prdata <= {24'h000000, fmt};
                end
                for (int i = 0; i < 4; i++)
                begin
                    if (paddr == OFS_CHO0 + 12'(4 * i))
                    begin
                        prdata <= cho_r[i];
                    end
                end
            end
        end
    end

    // ==========================================================
    // Effective configuration
    logic use_dip;
    logic quad;
    logic brk_en;
    logic reset_cmd;
    qco_cfg_t cfg [4];
    qco_cfg_t dip_cfg;

    function automatic qco_cfg_t reg2cfg(input logic [31:0] r);
        qco_cfg_t c;
        c.mode = qco_mode_t'(r[CB_MODE +: 2]);
        c.main_b = r[CB_MAINB];
        c.rule_lol = r[CB_LOL];
        c.latch = r[CB_LATCH];
        c.hold_ms = r[CB_HOLD +: 13] > TIME_MAX_MS_W ? TIME_MAX_MS_W : r[CB_HOLD +: 13];
        c.lock_ms = r[CB_LOCK +: 13] > TIME_MAX_MS_W ? TIME_MAX_MS_W : r[CB_LOCK +: 13];
        return c;
    endfunction

    assign use_dip = local_override_switch[DIP_OVR];
    assign quad = use_dip ? local_override_switch[DIP_QUAD] : global_r[GB_QUAD];
    assign brk_en = global_r[GB_BREAK];
    assign reset_cmd = global_r[GB_RESET];

    // Local switches carry no times; timers then run at zero
    always_comb
    begin
        dip_cfg = '0;
        dip_cfg.mode = QCO_MODE_AUTO;
        dip_cfg.main_b = local_override_switch[DIP_MAINB];
        dip_cfg.rule_lol = local_override_switch[DIP_LOL];
        dip_cfg.latch = local_override_switch[DIP_LATCH];
    end

    // Mode change only reroutes config; no state is flushed
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            cfg[i] = use_dip ? dip_cfg : reg2cfg(quad ? cho_r[0] : cho_r[i]);
        end
    end

    // ==========================================================
    // Millisecond tick
    logic [31:0] ms_cnt_r;
    logic ms_tick;

    assign ms_tick = ms_cnt_r == 32'(MS_DIV - 1);

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ms_cnt_r <= 32'h0000_0000;
        end
        else
        begin
            ms_cnt_r <= ms_tick ? 32'h0000_0000 : ms_cnt_r + 32'h1;
        end
    end

    // ==========================================================
    // Per-block health and timers
    logic [3:0] bad_a;
    logic [3:0] bad_b;
    logic [3:0] main_bad;
    logic [3:0] on_main;
    logic [3:0] want_backup;
    logic [3:0] want_main;
    logic [12:0] tmr_r [4];
    logic [3:0] latched_r;

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            bad_a[i] = cfg[i].rule_lol ? !health.lock_a[i] : !health.sig_a[i];
            bad_b[i] = cfg[i].rule_lol ? !health.lock_b[i] : !health.sig_b[i];
            main_bad[i] = cfg[i].main_b ? bad_b[i] : bad_a[i];
            on_main[i] = sel_b_r[i] == cfg[i].main_b;
            want_backup[i] = on_main[i] && main_bad[i] && tmr_r[i] > cfg[i].hold_ms;
            want_main[i] = !on_main[i] && !main_bad[i] && !cfg[i].latch &&
                tmr_r[i] > cfg[i].lock_ms;
        end
    end

    // Timer counts the current condition; any interruption restarts it
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 4; i++)
            begin
                tmr_r[i] <= 13'h0000;
            end
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (on_main[i] != main_bad[i])
                begin
                    tmr_r[i] <= 13'h0000;
                end
                else if (ms_tick && tmr_r[i] <= TIME_MAX_MS_W)
                begin
                    tmr_r[i] <= tmr_r[i] + 13'h1;
                end
            end
        end
    end

    // ==========================================================
    // Selection
    logic [3:0] sel_nxt;
    logic [2:0] good_a;
    logic [2:0] good_b;

    always_comb
    begin
        good_a = 3'h0;
        good_b = 3'h0;
        for (int i = 0; i < 4; i++)
        begin
            good_a = good_a + 3'(!bad_a[i]);
            good_b = good_b + 3'(!bad_b[i]);
            sel_nxt[i] = sel_b_r[i];
            if (cfg[i].mode == QCO_MODE_FIX_A)
            begin
                sel_nxt[i] = 1'b0;
            end
            else if (cfg[i].mode == QCO_MODE_FIX_B)
            begin
                sel_nxt[i] = 1'b1;
            end
            else if (!quad && (want_backup[i] || want_main[i]))
            begin
                sel_nxt[i] = !sel_b_r[i];
            end
            else if (!quad && reset_cmd && !main_bad[i])
            begin
                sel_nxt[i] = cfg[i].main_b;
            end
        end
        if (quad && cfg[0].mode == QCO_MODE_AUTO && ((|want_backup) || (&want_main) || reset_cmd ||
            (!on_main[0] && !good_a[2] && !good_b[2])))
        begin
            if (good_a == good_b)
            begin
                sel_nxt = {4{cfg[0].main_b}};
            end
            else
            begin
                sel_nxt = {4{good_b > good_a}};
            end
            if ((|latched_r) && !reset_cmd)
            begin
                sel_nxt = sel_b_r;
            end
        end
    end

    // Latch remembers a trip to backup until the reset command
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            latched_r <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (cfg[i].latch && want_backup[i])
                begin
                    latched_r[i] <= 1'b1;
                end
                else if (reset_cmd)
                begin
                    latched_r[i] <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Switch with optional defined break
    logic [31:0] brk_cnt_r;
    logic [3:0] brk_pend_r;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sel_b_r <= 4'h0;
            mute_r <= 4'h0;
            brk_cnt_r <= 32'h0000_0000;
            brk_pend_r <= 4'h0;
        end
        else if (|mute_r)
        begin
            if (ms_tick)
            begin
                brk_cnt_r <= brk_cnt_r + 32'h1;
            end
            if (brk_cnt_r >= 32'(BREAK_TICKS))
            begin
                sel_b_r <= brk_pend_r;
                mute_r <= 4'h0;
            end
        end
        else if (sel_nxt != sel_b_r)
        begin
            if (brk_en)
            begin
                mute_r <= 4'hF;
                brk_pend_r <= sel_nxt;
                brk_cnt_r <= 32'h0000_0000;
            end
            else
            begin
                sel_b_r <= sel_nxt;
            end
        end
    end

    // ==========================================================
    // Reclocker, equalizer, slew and locate
    logic [31:0] loc_ms_r;
    logic [31:0] loc_sec_r;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            output_port_sel_b <= 4'h0;
            output_port_mute <= 4'h0;
            rck_pass_thru <= 8'h00;
            eq_bypass <= 8'h00;
            slew_sd <= 4'h0;
        end
        else
        begin
            output_port_sel_b <= sel_b_r;
            output_port_mute <= mute_r;
            for (int i = 0; i < 8; i++)
            begin
                rck_pass_thru[i] <= (use_dip ? !local_override_switch[DIP_RCK] : !rck_enable_cfg[i]) ||
                    (autobypass_cfg[i] && !fmt.fmt_ok[i % 4]);
                eq_bypass[i] <= use_dip ? !local_override_switch[DIP_EQ] : eq_bypass_cfg[i];
            end
            for (int i = 0; i < 4; i++)
            begin
                slew_sd[i] <= fmt.below_sd[i];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            loc_ms_r <= 32'h0000_0000;
            loc_sec_r <= 32'h0000_0000;
            led_flash <= 1'b0;
        end
        else if (locate_go_r)
        begin
            loc_sec_r <= locate_s_r == 16'h0000 ? 32'(LOCATE_DEF_S) : 32'(locate_s_r);
            loc_ms_r <= 32'h0000_0000;
        end
        else if (loc_sec_r != 32'h0000_0000)
        begin
            led_flash <= loc_ms_r < 32'h0000_00FA || (loc_ms_r >= 32'h0000_01F4 && loc_ms_r < 32'h0000_02EE);
            if (ms_tick)
            begin
                loc_ms_r <= loc_ms_r == 32'h0000_03E7 ? 32'h0000_0000 : loc_ms_r + 32'h1;
                if (loc_ms_r == 32'h0000_03E7)
                begin
                    loc_sec_r <= loc_sec_r - 32'h1;
                end
            end
        end
        else
        begin
            led_flash <= 1'b0;
        end
    end
endmodule // qco_top
